// [gcb_cfg.svh]
// Constants of the global clock driver array
`ifndef GCB_CFG_SVH
`define GCB_CFG_SVH
`define GCB_LANES 16
`define GCB_CLK_PERIOD_NS 40
`define GCB_LOW 1'b0
`define GCB_HIGH 1'b1
`define GCB_PAIR_XOR 1
`endif

// [gcb_pkg.sv]
// Types shared by the global clock driver array
package gcb_pkg;

  typedef enum logic [1:0] {
    GCB_MODE_OFF,
    GCB_MODE_BUF,
    GCB_MODE_GATE,
    GCB_MODE_MUX
  } gcb_mode_t;

  typedef enum logic [1:0] {
    GCB_SRC_PAD,
    GCB_SRC_MGR,
    GCB_SRC_LOCAL,
    GCB_SRC_NONE
  } gcb_src_t;

  typedef enum logic [1:0] {
    GCB_MX_START,
    GCB_MX_FIRST,
    GCB_MX_RUN,
    GCB_MX_HOLD
  } gcb_mux_st_t;

  typedef struct packed {
    gcb_mode_t mode;
    logic falling;
    gcb_src_t first_src;
    gcb_src_t second_src;
  } gcb_cfg_t;

  typedef struct packed {
    logic prev_a;
    logic prev_b;
    logic pass;
    logic sel;
    gcb_mux_st_t st;
    logic out;
  } gcb_lane_t;

endpackage

// [gcb_top.sv]
// Array of global clock drivers: plain, gated and glitch-free switching
//
// How it works
// - Sixteen lanes, each a plain, gated or switching global driver.
// - Each clock input picks a pad, clock manager or local source.
// - Plain mode forwards the input clock unchanged to the output.
// - Lanes configured off hold their output static Low.
// - Falling option swaps edges and levels of gated and switching lanes, not enable or select levels.
// - Enable High before a rising edge passes that whole pulse.
// - Enable Low before a rising edge blocks the pulse, output Low.
// - Enable changes while the input clock is High are ignored.
// - Select Low routes first_clock_in, High routes second_clock_in.
// - Switching never yields a phase shorter than either input's phases.
// - Select changes wait while the current clock is High.
// - Output held Low until the next clock falls, then it drives.
// - Clocks may be asynchronous; select must settle before rising edges.
`timescale 1ns/1ps
`include "gcb_cfg.svh"

module gcb_top (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [`GCB_LANES-1:0] PAD_CLK_I,
  input wire logic [`GCB_LANES-1:0] MGR_CLK_I,
  input wire logic [`GCB_LANES-1:0] LOCAL_CLK_I,
  input wire gcb_pkg::gcb_cfg_t [`GCB_LANES-1:0] LANE_CFG_I,
  input wire logic [`GCB_LANES-1:0] ENABLE_I,
  input wire logic [`GCB_LANES-1:0] SELECT_I,
  output logic [`GCB_LANES-1:0] GLOBAL_CLK_O
);

  // Every clock input is a level sampled on CLK_I, so each lane answers
  // one CLK_I cycle late and only sees phases of one CLK_I period or more.
  // A source must run below half the CLK_I rate or it aliases.
  // Configuration is static: changing a lane's mode or edge while
  // running may cut one output phase short.

  localparam gcb_pkg::gcb_lane_t LANE_RST = '{
    prev_a: `GCB_LOW,
    prev_b: `GCB_LOW,
    pass: `GCB_LOW,
    sel: `GCB_LOW,
    st: gcb_pkg::GCB_MX_START,
    out: `GCB_LOW
  };

  // Each lane keeps the last samples of both inputs, the latched enable,
  // the latched select, the switching state and the output level, which
  // drives its pin directly
  gcb_pkg::gcb_lane_t [`GCB_LANES-1:0] lane_reg;
  gcb_pkg::gcb_lane_t [`GCB_LANES-1:0] lane_next;

  // Source choice is shared by both clock inputs of every lane
  function automatic logic pick_src(input gcb_pkg::gcb_src_t src,
                                    input logic pad, input logic mgr,
                                    input logic loc);
    case (src)
      gcb_pkg::GCB_SRC_PAD: pick_src = pad;
      gcb_pkg::GCB_SRC_MGR: pick_src = mgr;
      gcb_pkg::GCB_SRC_LOCAL: pick_src = loc;
      // An unconnected source reads as a quiet Low
      default: pick_src = `GCB_LOW;
    endcase
  endfunction

  // Current and next clock swap roles with the latched select
  function automatic logic sel_pick(input logic sel, input logic x,
                                    input logic y);
    sel_pick = sel ? y : x;
  endfunction

  // A fall is a High sample followed by a Low sample
  function automatic logic saw_fall(input logic prev, input logic now);
    saw_fall = prev & ~now;
  endfunction

  // Switching state machine of one lane in the rising-edge frame
  function automatic gcb_pkg::gcb_lane_t mux_step(
      input gcb_pkg::gcb_lane_t cur_st, input logic a, input logic b,
      input logic s);
    gcb_pkg::gcb_lane_t nx;
    logic cur;
    logic cur_prev;
    logic nxt;
    logic nxt_prev;
    nx = cur_st;
    cur = sel_pick(cur_st.sel, a, b);
    cur_prev = sel_pick(cur_st.sel, cur_st.prev_a, cur_st.prev_b);
    nxt = sel_pick(cur_st.sel, b, a);
    nxt_prev = sel_pick(cur_st.sel, cur_st.prev_b, cur_st.prev_a);
    case (cur_st.st)
      // Latch the select once, after reset or on entering mux mode
      gcb_pkg::GCB_MX_START: begin
        nx.sel = s;
        nx.st = gcb_pkg::GCB_MX_FIRST;
        nx.out = `GCB_LOW;
      end
      gcb_pkg::GCB_MX_FIRST: begin
        nx.out = `GCB_LOW;
        // Driving only after a full fall avoids a short first phase
        if (saw_fall(cur_prev, cur)) begin
          nx.st = gcb_pkg::GCB_MX_RUN;
        end
      end
      gcb_pkg::GCB_MX_RUN: begin
        // A change seen while High waits for the Low phase
        if ((s != cur_st.sel) && !cur) begin
          nx.st = gcb_pkg::GCB_MX_HOLD;
          nx.out = `GCB_LOW;
        end else begin
          nx.out = cur;
        end
      end
      gcb_pkg::GCB_MX_HOLD: begin
        // Handing over only on a fall of the new clock keeps every
        // output phase at least as long as an input phase
        nx.out = `GCB_LOW;
        if (saw_fall(nxt_prev, nxt)) begin
          nx.sel = !cur_st.sel;
          nx.st = gcb_pkg::GCB_MX_RUN;
        end
      end
      default: begin
        nx.st = gcb_pkg::GCB_MX_START;
        nx.out = `GCB_LOW;
      end
    endcase
    mux_step = nx;
  endfunction

  // Falling variant works on inverted clocks, enable/select untouched
  function automatic logic norm_clk(input logic lvl, input logic falling);
    norm_clk = lvl ^ falling;
  endfunction

  // Gated driver: enable is latched only while the clock is Low
  function automatic gcb_pkg::gcb_lane_t gate_step(
      input gcb_pkg::gcb_lane_t cur_st, input logic a, input logic en);
    gcb_pkg::gcb_lane_t nx;

    nx = cur_st;
    // Freezing the enable over the High phase avoids runt pulses
    nx.pass = a ? cur_st.pass : en;
    nx.out = a & cur_st.pass;
    // Switching state rests so a later mux mode resamples select
    nx.st = gcb_pkg::GCB_MX_START;
    gate_step = nx;
  endfunction

  // One lane for one cycle; output comes back in the lane's own sense
  function automatic gcb_pkg::gcb_lane_t lane_step(
      input gcb_pkg::gcb_lane_t cur_st, input gcb_pkg::gcb_cfg_t cfg,
      input logic raw_a, input logic raw_b, input logic en,
      input logic s);
    gcb_pkg::gcb_lane_t nx;
    logic a;
    logic b;

    a = norm_clk(raw_a, cfg.falling);
    b = norm_clk(raw_b, cfg.falling);
    nx = LANE_RST;
    case (cfg.mode)
      gcb_pkg::GCB_MODE_BUF: begin
        // No state: the plain driver forwards the raw level
        nx.out = raw_a;
      end
      gcb_pkg::GCB_MODE_GATE: begin
        nx = gate_step(cur_st, a, en);
        nx.out = norm_clk(nx.out, cfg.falling);
      end
      gcb_pkg::GCB_MODE_MUX: begin
        nx = mux_step(cur_st, a, b, s);
        nx.out = norm_clk(nx.out, cfg.falling);
      end
      default: begin
        // Unused branches stay static to save power
        nx = LANE_RST;
      end
    endcase
    nx.prev_a = a;
    nx.prev_b = b;
    lane_step = nx;
  endfunction

  always_comb begin
    logic raw_a;
    logic raw_b;
    int j;

    raw_a = `GCB_LOW;
    raw_b = `GCB_LOW;
    j = 0;
    lane_next = lane_reg;
    for (int i = 0; i < `GCB_LANES; i++) begin
      // Second input comes from the paired neighbour lane
      j = i ^ `GCB_PAIR_XOR;
      raw_a = pick_src(LANE_CFG_I[i].first_src, PAD_CLK_I[i],
                       MGR_CLK_I[i], LOCAL_CLK_I[i]);
      raw_b = pick_src(LANE_CFG_I[i].second_src, PAD_CLK_I[j],
                       MGR_CLK_I[j], LOCAL_CLK_I[j]);
      lane_next[i] = lane_step(lane_reg[i], LANE_CFG_I[i], raw_a, raw_b,
                               ENABLE_I[i], SELECT_I[i]);
    end
  end

  // Synchronous reset clears every lane to a quiet Low
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      lane_reg <= {`GCB_LANES{LANE_RST}};
    end else begin
      lane_reg <= lane_next;
    end
  end

  // Pins come straight from the out field of each lane register
  always_comb begin
    for (int i = 0; i < `GCB_LANES; i++) begin
      GLOBAL_CLK_O[i] = lane_reg[i].out;
    end
  end

endmodule // gcb_top

// [gcb_top_asserts.sv]
// Checker for the lanes as the bench sets them up
`timescale 1ns/1ps
module gcb_asserts (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [15:0] PAD_CLK_I,
  input wire logic [15:0] MGR_CLK_I,
  input wire logic [15:0] ENABLE_I,
  input wire logic [15:0] SELECT_I,
  input wire logic [15:0] GLOBAL_CLK_O
);
  wire [15:0] p = PAD_CLK_I, g = GLOBAL_CLK_O, e = ENABLE_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_arm; e[2] && !p[2] ##1 p[2]; endsequence
  sequence s_fall; ##[0:16] $fell(MGR_CLK_I[2]); endsequence
  property p_buf; !$past(SRST_I, 2) |-> g[0] == $past(p[0]); endproperty
  a_buf: assert property (p_buf) else $error("plain");
  property p_off; !g[1]; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_pass; s_arm |=> g[2]; endproperty
  a_pass: assert property (p_pass) else $error("pass");
  property p_block; !e[2] && !p[2] |-> ##2 !g[2]; endproperty
  a_block: assert property (p_block) else $error("block");
  property p_hold; g[2] && p[2] |=> g[2]; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_inv; !e[4] && p[4] |-> ##2 g[4]; endproperty
  a_inv: assert property (p_inv) else $error("falling");
  property p_wait; $rose(SELECT_I[3]) && p[3] |=> g[3]; endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_swap;
    $rose(SELECT_I[3]) && !p[3] |=> !g[3] throughout s_fall;
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
endmodule // gcb_asserts
bind gcb_top gcb_asserts u_chk (.CLK_I, .SRST_I, .PAD_CLK_I, .MGR_CLK_I,
  .ENABLE_I, .SELECT_I, .GLOBAL_CLK_O);

// [gcb_fabric.sv]
// Fabric model: source clock phases, enable and select
`timescale 1ns/1ps
module gcb_fabric (
  input wire logic clk_i,
  input wire logic [1:0] req_i,
  output logic [2:0] cnt_o,
  output logic [1:0] ctl_o
);
  logic [2:0] cnt_reg = 3'h0;
  always_ff @(posedge clk_i) cnt_reg <= cnt_reg + 3'h1;
  assign cnt_o = cnt_reg;
  // Select may move on any edge: lanes sample it, no setup hazard
  assign ctl_o = req_i;
endmodule // gcb_fabric

// [gcb_tb.sv]
// Bench driving four configured lanes from a fabric model
`timescale 1ns/1ps
module tb_top;
  logic CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic [1:0] req = 2'h0;
  logic [1:0] ctl;
  logic [2:0] c;
  logic [15:0] o;
  logic [4:0] x;
  gcb_pkg::gcb_cfg_t [15:0] cfg = '0;
  int n_errors = 0;
  int samples_checked = 0;
  always #20 CLK_I = ~CLK_I;
  gcb_fabric u_fab (.clk_i(CLK_I), .req_i(req), .cnt_o(c), .ctl_o(ctl));
  gcb_top dut (.CLK_I, .SRST_I, .PAD_CLK_I({16{c[1]}}),
    .MGR_CLK_I({16{c[2]}}), .LOCAL_CLK_I({16{c[0]}}), .LANE_CFG_I(cfg),
    .ENABLE_I({16{ctl[0]}}), .SELECT_I({16{ctl[1]}}), .GLOBAL_CLK_O(o));
  task automatic chk(input logic [4:0] exp);
    samples_checked++;
    if (o !== {11'h000, exp}) begin
      n_errors++;
      $display("unexpected GLOBAL_CLK_O exp %h got %h", {11'h000, exp}, o);
    end
  endtask
  // Lets any handover finish, then lanes 0 to 4 must match the model and lanes 5 to 15 stay Low
  task automatic judge;
    logic [2:0] v;
    repeat (24) @(posedge CLK_I);
    @(negedge CLK_I);
    v = c;
    repeat (8) begin
      @(negedge CLK_I);
      x = {~req[0] | v[1], req[1] ? v[2] : v[1], req[0] & v[1], 1'b0, v[1]};
      chk(x);
      v = c;
    end
  endtask
  task automatic t_pass;
    req <= 2'h1;
    judge();
  endtask
  task automatic t_late;
    @(posedge CLK_I iff c[1:0] == 2'h1);
    req <= 2'h3;
    judge();
  endtask
  task automatic t_swap;
    req <= 2'h0;
    judge();
    @(posedge CLK_I iff c[1:0] == 2'h3);
    req <= 2'h2;
    judge();
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Tests need about 145 cycles; this waits far longer
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial begin
    cfg[0].mode = gcb_pkg::GCB_MODE_BUF;
    cfg[2].mode = gcb_pkg::GCB_MODE_GATE;
    cfg[3].mode = gcb_pkg::GCB_MODE_MUX;
    cfg[3].second_src = gcb_pkg::GCB_SRC_MGR;
    cfg[4].mode = gcb_pkg::GCB_MODE_GATE;
    cfg[4].falling = 1'b1;
    repeat (6) @(posedge CLK_I);
    chk(5'h00);
    SRST_I <= 1'b0;
    t_pass();
    t_late();
    t_swap();
    wrap_up();
  end
endmodule // tb_top
